/* design/pmsvs_regs.sv */
// sleep voltage, rail four voltage and emergency shutdown registers
`timescale 1ns/10ps
module pmsvs_regs #(
    parameter bit RAIL1_USES_SECOND_PIN = 1'b0,
    parameter bit RAIL2_USES_SECOND_PIN = 1'b1
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // register access from the serial-bus slave
    input wire logic [7:0] reg_addr,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_ack,
    // sleep-select pins
    input wire logic first_sleep_select_pin,
    input wire logic second_sleep_select_pin,
    // normal codes of rails one and two
    input wire logic [6:0] rail1_normal_voltage_code,
    input wire logic [6:0] rail2_normal_voltage_code,
    // selected targets of rails one and two
    output logic [6:0] rail1_target_code,
    output logic [6:0] rail2_target_code,
    output logic rail1_in_sleep,
    output logic rail2_in_sleep,
    // rail four settings
    output logic [6:0] rail4_normal_voltage_code,
    output logic rail4_decay_select,
    output logic [6:0] rail4_sleep_voltage_code,
    // device-wide shutdown
    output logic emergency_shutdown
);
    logic [7:0] rail1_ctrl;
    logic [7:0] rail2_ctrl;
    logic [7:0] rail4_normal;
    logic [6:0] rail4_sleep;
    logic [1:0] pins_sync;
    logic [7:0] next_rdata;
    logic [6:0] next_rail1_target;
    logic [6:0] next_rail2_target;

    pmsvs_sync #(
        .WIDTH(2)
    ) u_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .async_in({second_sleep_select_pin, first_sleep_select_pin}),
        .sync_out(pins_sync)
    );

    // address decode
    wire hit_shutdown = reg_addr == pmsvs_pkg::OFFSET_SHUTDOWN;
    wire hit_rail1 = reg_addr == pmsvs_pkg::OFFSET_RAIL1_SLEEP;
    wire hit_rail2 = reg_addr == pmsvs_pkg::OFFSET_RAIL2_SLEEP;
    wire hit_rail4_normal = reg_addr == pmsvs_pkg::OFFSET_RAIL4_NORMAL;
    wire hit_rail4_sleep = reg_addr == pmsvs_pkg::OFFSET_RAIL4_SLEEP;
    wire hit_any = hit_shutdown | hit_rail1 | hit_rail2 | hit_rail4_normal
        | hit_rail4_sleep;
    wire write_ok = reg_write & ~emergency_shutdown;
    wire shutdown_write = write_ok & hit_shutdown
        & reg_wdata[pmsvs_pkg::FORCE_SHUTDOWN_POS];
    assign reg_ack = (reg_write | reg_read) & hit_any
        & ~shutdown_write;

    // read mux
    assign next_rdata =
        hit_shutdown ? {7'h00, emergency_shutdown} :
        hit_rail1 ? rail1_ctrl :
        hit_rail2 ? rail2_ctrl :
        hit_rail4_normal ? rail4_normal :
        hit_rail4_sleep ? {rail4_sleep, 1'b0} :
        8'h00;

    // sleep pin choice and code selection
    wire rail1_pin = RAIL1_USES_SECOND_PIN
        ? pins_sync[1] : pins_sync[0];
    wire rail2_pin = RAIL2_USES_SECOND_PIN
        ? pins_sync[1] : pins_sync[0];
    wire rail1_sleep_now = rail1_ctrl[pmsvs_pkg::SLEEP_ENABLE_POS]
        & ~rail1_pin;
    wire rail2_sleep_now = rail2_ctrl[pmsvs_pkg::SLEEP_ENABLE_POS]
        & ~rail2_pin;
    assign next_rail1_target = rail1_sleep_now
        ? rail1_ctrl[pmsvs_pkg::CODE_MSB:pmsvs_pkg::CODE_LSB]
        : rail1_normal_voltage_code;
    assign next_rail2_target = rail2_sleep_now
        ? rail2_ctrl[pmsvs_pkg::CODE_MSB:pmsvs_pkg::CODE_LSB]
        : rail2_normal_voltage_code;

    // rail four fields
    assign rail4_normal_voltage_code =
        rail4_normal[pmsvs_pkg::CODE_MSB:pmsvs_pkg::CODE_LSB];
    assign rail4_decay_select =
        rail4_normal[pmsvs_pkg::DECAY_SELECT_POS];
    assign rail4_sleep_voltage_code = rail4_sleep;

    // force-shutdown bit, pulses for one cycle
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            emergency_shutdown <= 1'b0;
        else
            emergency_shutdown <= shutdown_write;
    end

    // storage, cleared by the shutdown
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rail1_ctrl <= pmsvs_pkg::RESET_RAIL_REG;
            rail2_ctrl <= pmsvs_pkg::RESET_RAIL_REG;
            rail4_normal <= pmsvs_pkg::RESET_RAIL_REG;
            rail4_sleep <= pmsvs_pkg::RESET_CODE;
        end
        else if (emergency_shutdown)
        begin
            rail1_ctrl <= pmsvs_pkg::RESET_RAIL_REG;
            rail2_ctrl <= pmsvs_pkg::RESET_RAIL_REG;
            rail4_normal <= pmsvs_pkg::RESET_RAIL_REG;
            rail4_sleep <= pmsvs_pkg::RESET_CODE;
        end
        else if (write_ok)
        begin
            if (hit_rail1)
                rail1_ctrl <= reg_wdata;
            if (hit_rail2)
                rail2_ctrl <= reg_wdata;
            if (hit_rail4_normal)
                rail4_normal <= reg_wdata;
            if (hit_rail4_sleep)
                rail4_sleep <= reg_wdata[7:1];
        end
    end

    // targets and read data
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rail1_target_code <= pmsvs_pkg::RESET_CODE;
            rail2_target_code <= pmsvs_pkg::RESET_CODE;
            rail1_in_sleep <= 1'b0;
            rail2_in_sleep <= 1'b0;
            reg_rdata <= pmsvs_pkg::RESET_SHUTDOWN;
        end
        else
        begin
            rail1_target_code <= next_rail1_target;
            rail2_target_code <= next_rail2_target;
            rail1_in_sleep <= rail1_sleep_now;
            rail2_in_sleep <= rail2_sleep_now;
            if (reg_read)
                reg_rdata <= next_rdata;
        end
    end

    // checks
    property p_shutdown_clears;
        @(posedge clk_sys) disable iff (!reset_n)
        shutdown_write |=> emergency_shutdown ##1 (rail1_ctrl == 8'h00
            && rail2_ctrl == 8'h00 && rail4_normal == 8'h00);
    endproperty
    a_shutdown_clears: assert property (p_shutdown_clears)
        else $error("shutdown did not clear registers");

    property p_zero_no_action;
        @(posedge clk_sys) disable iff (!reset_n)
        (reg_write && hit_shutdown && !reg_wdata[0]) |=> !emergency_shutdown;
    endproperty
    a_zero_no_action: assert property (p_zero_no_action)
        else $error("writing zero started a shutdown");

    property p_self_clear;
        @(posedge clk_sys) disable iff (!reset_n)
        emergency_shutdown |=> !emergency_shutdown;
    endproperty
    a_self_clear: assert property (p_self_clear)
        else $error("force-shutdown bit stayed set");

    property p_no_ack;
        @(posedge clk_sys) disable iff (!reset_n)
        (reg_write && hit_shutdown && reg_wdata[0] && !emergency_shutdown)
            |-> !reg_ack;
    endproperty
    a_no_ack: assert property (p_no_ack)
        else $error("shutdown write was acknowledged");

    property p_reserved_zero;
        @(posedge clk_sys) disable iff (!reset_n)
        (reg_read && hit_shutdown) |=> reg_rdata[7:1] == 7'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("shutdown reserved bits read nonzero");

    property p_rail1_sleep;
        @(posedge clk_sys) disable iff (!reset_n)
        (rail1_ctrl[0] && !rail1_pin)
            |=> rail1_target_code == $past(rail1_ctrl[7:1]) && rail1_in_sleep;
    endproperty
    a_rail1_sleep: assert property (p_rail1_sleep)
        else $error("rail one did not take its sleep code");

    property p_rail1_normal;
        @(posedge clk_sys) disable iff (!reset_n)
        !rail1_ctrl[0]
            |=> rail1_target_code == $past(rail1_normal_voltage_code);
    endproperty
    a_rail1_normal: assert property (p_rail1_normal)
        else $error("rail one left its normal code while disabled");

    property p_rail2_pin;
        @(posedge clk_sys) disable iff (!reset_n)
        (rail2_ctrl[0] && rail2_pin)
            |=> rail2_target_code == $past(rail2_normal_voltage_code)
            && !rail2_in_sleep;
    endproperty
    a_rail2_pin: assert property (p_rail2_pin)
        else $error("rail two slept with its pin high");

    property p_rail4_sleep_read;
        @(posedge clk_sys) disable iff (!reset_n)
        (reg_read && hit_rail4_sleep)
            |=> reg_rdata == {$past(rail4_sleep), 1'b0};
    endproperty
    a_rail4_sleep_read: assert property (p_rail4_sleep_read)
        else $error("rail four sleep register read wrong");

    property p_rail4_write;
        @(posedge clk_sys) disable iff (!reset_n)
        (write_ok && hit_rail4_normal) |=> {rail4_normal_voltage_code,
            rail4_decay_select} == $past(reg_wdata);
    endproperty
    a_rail4_write: assert property (p_rail4_write)
        else $error("rail four write not stored");
endmodule

/* design/pmsvs_sync.sv */
// two-stage synchroniser for the sleep-select pins
`timescale 1ns/10ps
module pmsvs_sync #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // pins and synchronised levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stage1 <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

/* shared/pmsvs_pkg.sv */
// register map and constants for the sleep voltage and shutdown registers
package pmsvs_pkg;
    localparam int CODE_WIDTH = 7;
    localparam int REG_WIDTH = 8;
    // register offsets
    localparam logic [7:0] OFFSET_SHUTDOWN = 8'h91;
    localparam logic [7:0] OFFSET_RAIL1_SLEEP = 8'h92;
    localparam logic [7:0] OFFSET_RAIL2_SLEEP = 8'h93;
    localparam logic [7:0] OFFSET_RAIL4_NORMAL = 8'h94;
    localparam logic [7:0] OFFSET_RAIL4_SLEEP = 8'h95;
    // field positions
    localparam int FORCE_SHUTDOWN_POS = 0;
    localparam int SLEEP_ENABLE_POS = 0;
    localparam int DECAY_SELECT_POS = 0;
    localparam int CODE_LSB = 1;
    localparam int CODE_MSB = 7;
    // values after reset
    localparam logic [7:0] RESET_SHUTDOWN = 8'h00;
    localparam logic [7:0] RESET_RAIL_REG = 8'h00;
    localparam logic [6:0] RESET_CODE = 7'h00;
endpackage

/* test/pmsvs_host.sv */
// host model issuing single-byte register reads and writes
`timescale 1ns/10ps
module pmsvs_host (
    // clock
    input wire logic clk_sys,
    // register port
    output logic [7:0] reg_addr,
    output logic reg_write,
    output logic reg_read,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_ack
);
    initial
    begin
        reg_addr = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_wdata = 8'h00;
    end
    // a missing ack is handed back, never treated as a bus fault
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
        output logic ack);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        ack = reg_ack;
        reg_write <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
        output logic ack);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        ack = reg_ack;
        reg_read <= 1'b0;
        @(posedge clk_sys);
        d = reg_rdata;
    endtask
endmodule

/* test/testbench.sv */
// self-checking bench for the sleep voltage and shutdown registers
`timescale 1ns/10ps
module testbench;
    logic clk_sys, reset_n, reg_write, reg_read, reg_ack, ack;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic pin1, pin2, in1, in2, decay, shut;
    logic [6:0] n1, n2, t1, t2, r4n, r4s;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    pmsvs_regs i_dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_write(reg_write), .reg_read(reg_read),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .first_sleep_select_pin(pin1), .second_sleep_select_pin(pin2),
        .rail1_normal_voltage_code(n1), .rail2_normal_voltage_code(n2),
        .rail1_target_code(t1), .rail2_target_code(t2),
        .rail1_in_sleep(in1), .rail2_in_sleep(in2),
        .rail4_normal_voltage_code(r4n), .rail4_decay_select(decay),
        .rail4_sleep_voltage_code(r4s), .emergency_shutdown(shut)
    );
    pmsvs_host i_host (
        .clk_sys(clk_sys), .reg_addr(reg_addr), .reg_write(reg_write),
        .reg_read(reg_read), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_ack(reg_ack)
    );
    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic end_sim();
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrc(input logic [7:0] a, input logic [7:0] v,
        input logic eack);
        i_host.wr(a, v, ack);
        check({7'h00, ack}, {7'h00, eack});
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp,
        input logic eack);
        i_host.rd(a, d, ack);
        check({7'h00, ack}, {7'h00, eack});
        check(d, exp);
    endtask
    task automatic pins(input logic p1, input logic p2);
        pin1 <= p1;
        pin2 <= p2;
        repeat (4) @(posedge clk_sys);
    endtask
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            mismatches++;
            end_sim();
        end
    end
    initial
    begin
        reset_n = 1'b0;
        pin1 = 1'b1;
        pin2 = 1'b1;
        n1 = 7'h11;
        n2 = 7'h22;
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        for (int i = 0; i < 5; i++)
            rdc(8'h91 + i[7:0], 8'h00, 1'b1);
        rdc(8'h90, 8'h00, 1'b0);
        $display("reset values done");
        wrc(8'h94, 8'ha5, 1'b1);
        rdc(8'h94, 8'ha5, 1'b1);
        check({1'b0, r4n}, 8'h52);
        check({7'h00, decay}, 8'h01);
        wrc(8'h95, 8'hff, 1'b1);
        rdc(8'h95, 8'hfe, 1'b1);
        check({1'b0, r4s}, 8'h7f);
        wrc(8'h92, 8'hff, 1'b1);
        rdc(8'h92, 8'hff, 1'b1);
        wrc(8'h91, 8'hfe, 1'b1);
        rdc(8'h91, 8'h00, 1'b1);
        rdc(8'h94, 8'ha5, 1'b1);
        wrc(8'h96, 8'h5a, 1'b0);
        $display("access done");
        wrc(8'h92, {7'h3c, 1'b1}, 1'b1);
        wrc(8'h93, {7'h45, 1'b0}, 1'b1);
        pins(1'b0, 1'b0);
        check({in1, t1}, 8'hbc);
        check({in2, t2}, 8'h22);
        pins(1'b1, 1'b0);
        check({in1, t1}, 8'h11);
        wrc(8'h93, {7'h45, 1'b1}, 1'b1);
        pins(1'b1, 1'b0);
        check({in2, t2}, 8'hc5);
        pins(1'b0, 1'b1);
        check({in2, t2}, 8'h22);
        check({in1, t1}, 8'hbc);
        $display("sleep select done");
        wrc(8'h91, 8'h01, 1'b0);
        @(posedge clk_sys);
        check({7'h00, shut}, 8'h01);
        @(posedge clk_sys);
        check({7'h00, shut}, 8'h00);
        rdc(8'h91, 8'h00, 1'b1);
        for (int i = 1; i < 5; i++)
            rdc(8'h91 + i[7:0], 8'h00, 1'b1);
        check({r4n, decay}, 8'h00);
        n1 <= 7'h33;
        repeat (2) @(posedge clk_sys);
        check({in1, t1}, 8'h33);
        $display("shutdown done");
        wrc(8'h94, 8'h3c, 1'b1);
        rdc(8'h94, 8'h3c, 1'b1);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        rdc(8'h94, 8'h00, 1'b1);
        rdc(8'h91, 8'h00, 1'b1);
        $display("second reset done");
        end_sim();
    end
endmodule
